//--- hw/mcu_clock_generation.sv
// Purpose: Root clock selection, programmable divider and derived clock ticks
// Assumes: Oscillators arrive as slow square waves sampled on core_clk
// Notes:   Derived clocks are one-cycle tick pulses plus toggling pin levels
//
// Functional notes
// - A machine cycle spans two CPU core clock cycles.
// - Peripheral clock runs at CPU core clock divided by two.
// - Selected root oscillator feeds the divider whose output is the CPU clock.
// - Internal RC oscillator is a selectable root source, nominally 7.373 MHz.
// - Oscillator source comes from stored configuration, never a register write.
// - Crystal ranges: 20-100 kHz, 100 kHz-4 MHz, 4-18 MHz.
// - Every reset clears the low-power bit.
// - Clock output only when crystal unused by root source and real-time clock.
// - Clock output pin is driven only while its enable bit is set.
// - Clock output toggles at half the CPU clock; software may turn it off.
// - A writable 6-bit field tunes the RC oscillator frequency.
// - Only power-on reset loads the factory tune value; other resets keep it.
// - Watchdog oscillator at 400 kHz is a selectable low-power root source.
// - External clock on crystal input from 0 Hz to 18 MHz; output pin freed.
// - Divider ratio up to 510, changeable any time without halting.
// - Crystal source holds CPU clock off for 992 root cycles plus 60-100 us.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "clock_gen_defs.svh"

module mcu_clock_generation #(
  parameter int unsigned WAKE_TIME_CYCLES = `WAKE_TIME_CYCLES,
  parameter int unsigned DIV_W            = 8
) (
  // Clock and resets
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             por_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Oscillator inputs and configuration
  input  wire logic             internal_rc_clock,
  input  wire logic             watchdog_osc_clock,
  input  wire logic             crystal_in_pin,
  input  wire logic [2:0]       osc_config,
  input  wire logic [5:0]       factory_tune,
  input  wire logic             rtc_uses_crystal,
  // Derived clock ticks, low-power clock bit and RC tune value
  output logic                  cpu_core_tick,
  output logic                  machine_cycle_tick,
  output logic                  periph_clock_tick,
  output logic                  low_power_clock_bit,
  output logic [5:0]            rc_tune_value,
  // Crystal output pin
  output logic                  crystal_out_pin_o,
  output logic                  crystal_out_pin_oe
);

  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr

  localparam int unsigned WT_W = $clog2(WAKE_TIME_CYCLES + 1);

  // Oscillator pins are asynchronous: three stages, edge taken from stages two and three
  logic [2:0] osc_raw;
  logic [2:0] osc_s1_r;
  logic [2:0] osc_s2_r;
  logic [2:0] osc_s3_r;
  logic [2:0] osc_rise;
  assign osc_raw = {crystal_in_pin, watchdog_osc_clock, internal_rc_clock};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_osc_sync
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          osc_s1_r[g] <= 1'b0;
          osc_s2_r[g] <= 1'b0;
          osc_s3_r[g] <= 1'b0;
        end else begin
          osc_s1_r[g] <= osc_raw[g];
          osc_s2_r[g] <= osc_s1_r[g];
          osc_s3_r[g] <= osc_s2_r[g];
        end
      end
      assign osc_rise[g] = osc_s2_r[g] & ~osc_s3_r[g];
    end
  endgenerate

  // Configuration and real-time clock select, two-flop synchronised
  logic [2:0] cfg_s1_r;
  logic [2:0] cfg_s2_r;
  logic       rtc_s1_r;
  logic       rtc_s2_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_r <= 3'h0;
      cfg_s2_r <= 3'h0;
      rtc_s1_r <= 1'b0;
      rtc_s2_r <= 1'b0;
    end else begin
      cfg_s1_r <= osc_config;
      cfg_s2_r <= cfg_s1_r;
      rtc_s1_r <= rtc_uses_crystal;
      rtc_s2_r <= rtc_s1_r;
    end
  end

  // Start-up state
  clock_gen_pkg::clk_state_t state_r;
  clock_gen_pkg::clk_state_t state_nxt;
  logic [2:0]       osc_sel_r;
  logic [1:0]       settle_r;
  logic [9:0]       wake_root_r;
  logic [WT_W-1:0]  wake_time_r;

  // Source decode: crystal codes cover the three ranges, unknown codes fall back to RC
  logic       sel_xtal;
  logic       sel_wdt;
  logic       sel_ext;
  logic       root_tick;
  logic       xtal_busy;
  assign sel_xtal  = (osc_sel_r == `OSC_XTAL_LOW) | (osc_sel_r == `OSC_XTAL_MED)
                   | (osc_sel_r == `OSC_XTAL_HIGH);
  assign sel_wdt   = (osc_sel_r == `OSC_WATCHDOG);
  assign sel_ext   = (osc_sel_r == `OSC_EXT_CLK);
  assign root_tick = (sel_xtal | sel_ext) ? osc_rise[2] :
                     sel_wdt ? osc_rise[1] : osc_rise[0];
  assign xtal_busy = sel_xtal | rtc_s2_r;

  logic wake_root_done;
  logic wake_time_done;
  logic cfg_ready;
  assign wake_root_done = root_tick && (wake_root_r == `WAKE_ROOT_CYCLES - 10'd1);
  assign wake_time_done = (wake_time_r == WT_W'(WAKE_TIME_CYCLES - 1));
  assign cfg_ready      = (settle_r == `CFG_SETTLE);

  // Next state of the start-up sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      clock_gen_pkg::ST_CAPTURE:
        if (cfg_ready) begin
          state_nxt = (cfg_s2_r == `OSC_XTAL_LOW || cfg_s2_r == `OSC_XTAL_MED ||
                       cfg_s2_r == `OSC_XTAL_HIGH) ? clock_gen_pkg::ST_WAKE_ROOT
                                                  : clock_gen_pkg::ST_RUN;
        end
      clock_gen_pkg::ST_WAKE_ROOT:
        if (wake_root_done) begin
          state_nxt = clock_gen_pkg::ST_WAKE_TIME;
        end
      clock_gen_pkg::ST_WAKE_TIME:
        if (wake_time_done) begin
          state_nxt = clock_gen_pkg::ST_RUN;
        end
      clock_gen_pkg::ST_RUN:
        state_nxt = clock_gen_pkg::ST_RUN;
      default:
        state_nxt = clock_gen_pkg::ST_CAPTURE;
    endcase
  end

  // Source is latched once after reset release; no register path can change it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= clock_gen_pkg::ST_CAPTURE;
      osc_sel_r   <= `OSC_RC;
      settle_r    <= 2'd0;
      wake_root_r <= 10'd0;
      wake_time_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == clock_gen_pkg::ST_CAPTURE) begin
        settle_r <= settle_r + 2'd1;
        if (cfg_ready) begin
          osc_sel_r <= cfg_s2_r;
        end
      end
      if (state_r == clock_gen_pkg::ST_WAKE_ROOT && root_tick) begin
        wake_root_r <= wake_root_r + 10'd1;
      end
      if (state_r == clock_gen_pkg::ST_WAKE_TIME) begin
        wake_time_r <= wake_time_r + WT_W'(1);
      end
    end
  end

  // APB decode
  logic setup_ph;
  logic access_done;
  logic hit_div;
  logic hit_tune;
  logic hit_aux;
  logic hit_stat;
  logic hit_any;
  logic wr_en;
  assign setup_ph    = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign hit_div     = (paddr == reg_addr(`IDX_DIVIDE));
  assign hit_tune    = (paddr == reg_addr(`IDX_RC_TUNE));
  assign hit_aux     = (paddr == reg_addr(`IDX_AUX_ONE));
  assign hit_stat    = (paddr == reg_addr(`IDX_STATUS));
  assign hit_any     = hit_div | hit_tune | hit_aux | hit_stat;
  assign wr_en       = access_done & pwrite & hit_any;

  // Software registers
  logic [DIV_W-1:0] divide_r;
  logic             low_power_r;
  logic [5:0]       tune_r;
  logic             clkout_en_r;
  logic             por_load_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divide_r    <= DIV_W'(`DIVIDE_RST);
      low_power_r <= `LOW_POWER_RST;
    end else if (wr_en) begin
      if (hit_div) begin
        divide_r <= pwdata[DIV_W-1:0];
      end
      if (hit_aux) begin
        low_power_r <= pwdata[`AUX_LOW_POWER_BIT];
      end
    end
  end

  // Power-on flag; only it reloads the tune register, other resets leave it alone
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      por_load_r <= 1'b1;
    end else begin
      por_load_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (por_load_r) begin
      tune_r      <= factory_tune;
      clkout_en_r <= `TUNE_EN_RST;
    end else if (wr_en && hit_tune) begin
      tune_r      <= pwdata[`TUNE_VAL_MSB:0];
      clkout_en_r <= pwdata[`TUNE_CLKOUT_BIT];
    end
  end

  // Read mux
  clock_gen_pkg::clk_status_t status;
  logic [31:0] rd_word;
  assign status.osc_sel        = osc_sel_r;
  assign status.crystal_mode   = sel_xtal;
  assign status.clkout_allowed = ~xtal_busy;
  assign status.running        = (state_r == clock_gen_pkg::ST_RUN);
  assign rd_word = hit_div  ? {{(32-DIV_W){1'b0}}, divide_r} :
                   hit_tune ? {25'h0, clkout_en_r, tune_r} :
                   hit_aux  ? {24'h0, low_power_r, 7'h0} :
                   hit_stat ? {26'h0, status} : 32'h0;

  // No wait state: answer is prepared in setup, given in the first access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      prdata  <= (setup_ph & ~pwrite) ? rd_word : 32'h0;
    end
  end

  // Divider: ratio 1 for zero, else twice the value (up to 510)
  logic [DIV_W:0]   ratio_act;
  logic [DIV_W-1:0] divide_act_r;
  logic [DIV_W:0]   div_cnt_r;
  logic             run;
  logic             cpu_core_clock_edge;
  assign run       = (state_r == clock_gen_pkg::ST_RUN);
  assign ratio_act = (divide_act_r == '0) ? (DIV_W+1)'(1) : {divide_act_r, 1'b0};
  assign cpu_core_clock_edge = run & root_tick & (div_cnt_r == ratio_act - (DIV_W+1)'(1));

  // Ratio is swapped only on the output boundary so no phase is clipped
  logic mc_phase_r;
  logic clkout_lvl_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divide_act_r       <= DIV_W'(`DIVIDE_RST);
      div_cnt_r          <= '0;
      mc_phase_r         <= 1'b0;
      clkout_lvl_r       <= 1'b0;
      cpu_core_tick      <= 1'b0;
      machine_cycle_tick <= 1'b0;
      periph_clock_tick  <= 1'b0;
    end else begin
      cpu_core_tick      <= cpu_core_clock_edge;
      machine_cycle_tick <= cpu_core_clock_edge & mc_phase_r;
      periph_clock_tick  <= cpu_core_clock_edge & mc_phase_r;
      if (cpu_core_clock_edge) begin
        div_cnt_r    <= '0;
        divide_act_r <= divide_r;
        mc_phase_r   <= ~mc_phase_r;
        clkout_lvl_r <= ~clkout_lvl_r;
      end else if (run && root_tick) begin
        div_cnt_r <= div_cnt_r + (DIV_W+1)'(1);
      end
    end
  end

  // Pin and flag outputs, registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_out_pin_o   <= 1'b0;
      crystal_out_pin_oe  <= 1'b0;
      low_power_clock_bit <= 1'b0;
      rc_tune_value       <= 6'h00;
    end else begin
      crystal_out_pin_oe  <= clkout_en_r & ~xtal_busy & run;
      crystal_out_pin_o   <= clkout_lvl_r & clkout_en_r & ~xtal_busy;
      low_power_clock_bit <= low_power_r;
      rc_tune_value       <= tune_r;
    end
  end

endmodule : mcu_clock_generation
`default_nettype wire

//--- hw/clock_gen_defs.svh
// Purpose: Offsets, fields, reset values and timing counts of the clock generator
// Assumes: Core clock of 125 MHz; registers are word-spaced on APB
// Notes:   Definitions only; included by bare name
`ifndef CLOCK_GEN_DEFS_SVH
`define CLOCK_GEN_DEFS_SVH

// Core clock rate, used to turn times into cycle counts
`define CORE_CLK_MHZ      125
// Register indices; byte address is four times the index
`define IDX_DIVIDE        8'h95
`define IDX_RC_TUNE       8'h96
`define IDX_AUX_ONE       8'h97
`define IDX_STATUS        8'h98
// Field positions
`define TUNE_VAL_MSB      5
`define TUNE_CLKOUT_BIT   6
`define AUX_LOW_POWER_BIT 7
// Reset values
`define DIVIDE_RST        8'h00
`define TUNE_EN_RST       1'b0
`define LOW_POWER_RST     1'b0
// Oscillator selection codes from non-volatile configuration
`define OSC_XTAL_LOW      3'h0
`define OSC_XTAL_MED      3'h1
`define OSC_XTAL_HIGH     3'h2
`define OSC_RC            3'h3
`define OSC_WATCHDOG      3'h4
`define OSC_EXT_CLK       3'h7
// Oscillator figures in kHz
`define RC_NOMINAL_KHZ    7373
`define WDT_OSC_KHZ       400
`define XTAL_LOW_MIN_KHZ  20
`define XTAL_MED_MIN_KHZ  100
`define XTAL_HIGH_MIN_KHZ 4000
`define XTAL_HIGH_MAX_KHZ 18000
`define EXT_CLK_MAX_KHZ   18000
// Limits that board and software must respect
`define RST_PIN_NEED_KHZ  12000
`define LOW_POWER_MAX_KHZ 8000
// Wake-up delay: root cycles, then a least time in ns rounded up to core cycles
`define WAKE_ROOT_CYCLES  10'd992
`define WAKE_EXTRA_NS     60000
`define WAKE_TIME_CYCLES  ((`WAKE_EXTRA_NS * `CORE_CLK_MHZ + 999) / 1000)
// Settling cycles before the configuration is captured
`define CFG_SETTLE        2'd3
// Machine cycle length in CPU core clock cycles; peripheral divide ratio
`define MACHINE_CCLKS     2
`define PERIPH_DIV        2

`endif

//--- hw/clock_gen_pkg.sv
// Purpose: Types shared by the clock generator
// Assumes: Constants come from clock_gen_defs.svh
// Notes:   No constants here, only types
package clock_gen_pkg;

  // Start-up sequence, one-hot
  typedef enum logic [3:0] {
    ST_CAPTURE   = 4'b0001,
    ST_WAKE_ROOT = 4'b0010,
    ST_WAKE_TIME = 4'b0100,
    ST_RUN       = 4'b1000
  } clk_state_t;

  // Status word read back by software
  typedef struct packed {
    logic [2:0] osc_sel;
    logic       crystal_mode;
    logic       clkout_allowed;
    logic       running;
  } clk_status_t;

endpackage : clock_gen_pkg

//--- verif/osc_sources.sv
// Purpose: Oscillator sources on the far side of the clock generator
// Assumes: Core clock rises at 4 ns past each 8 ns step
// Notes:   Root edges land on whole 8 ns steps, clear of core sampling edges
`timescale 1ns/100ps
`default_nettype none
module osc_sources #(
  parameter int RC_HALF   = 4,
  parameter int WDT_HALF  = 6,
  parameter int XTAL_HALF = 5
) (
  // Free-running oscillator outputs
  output logic rc_clk,
  output logic wdt_clk,
  output logic xtal_clk
);
  // Rates are scaled down so each phase spans at least three core cycles
  initial begin
    rc_clk = 1'b0;
    wdt_clk = 1'b0;
    xtal_clk = 1'b0;
  end
  always #(RC_HALF * 8) rc_clk = ~rc_clk;
  always #(WDT_HALF * 8) wdt_clk = ~wdt_clk;
  // Crystal and external clock share one pin; 12.5 MHz here, just above the pin-reset rate
  always #(XTAL_HALF * 8) xtal_clk = ~xtal_clk;
endmodule : osc_sources
`default_nettype wire

//--- verif/clock_gen_assertions.sv
// Purpose: Port-level checks for the clock generator
// Assumes: One core clock domain, reset rst_n
// Notes:   Bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module clock_gen_assertions (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Clock side
  input wire logic [2:0]  osc_config,
  input wire logic        rtc_uses_crystal,
  input wire logic        cpu_core_tick,
  input wire logic        machine_cycle_tick,
  input wire logic        periph_clock_tick,
  input wire logic        low_power_clock_bit,
  input wire logic        crystal_out_pin_o,
  input wire logic        crystal_out_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] mcnt_r, pcnt_r;
  wire logic  mapped;
  // Fast ticks since the last slow tick; slow tick may lag its cause by one cycle
  assign mapped = paddr inside {12'h254, 12'h258, 12'h25c, 12'h260};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcnt_r <= 3'h0;
      pcnt_r <= 3'h0;
    end else begin
      mcnt_r <= machine_cycle_tick ? 3'h0 : mcnt_r + {2'h0, cpu_core_tick};
      pcnt_r <= periph_clock_tick ? 3'h0 : pcnt_r + {2'h0, cpu_core_tick};
    end
  end
  property p_setup_ready; psel && !penable |=> pready; endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_map; pready |-> pslverr == !mapped; endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside access");
  property p_mach; machine_cycle_tick |-> mcnt_r + {2'h0, cpu_core_tick} == 3'h2; endproperty
  a_mach: assert property (p_mach) else $error("machine tick spacing");
  property p_periph; periph_clock_tick |-> pcnt_r + {2'h0, cpu_core_tick} == 3'h2; endproperty
  a_periph: assert property (p_periph) else $error("peripheral tick spacing");
  property p_lp_reset; $rose(rst_n) |-> !low_power_clock_bit; endproperty
  a_lp_reset: assert property (p_lp_reset) else $error("low power bit after reset");
  property p_tick_gap; cpu_core_tick |=> !cpu_core_tick [*5]; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("short core clock period");
  property p_clkout_src; $rose(crystal_out_pin_oe) |-> !rtc_uses_crystal && osc_config > 3'h2;
  endproperty
  a_clkout_src: assert property (p_clkout_src) else $error("clock out with crystal");
  property p_clkout_tick;
    $changed(crystal_out_pin_o) && crystal_out_pin_oe && $past(crystal_out_pin_oe)
      |-> cpu_core_tick || $past(cpu_core_tick);
  endproperty
  a_clkout_tick: assert property (p_clkout_tick) else $error("clock out off tick");
  c_mach: cover property (machine_cycle_tick);
  c_err: cover property (pready && pslverr);
  c_clkout: cover property ($rose(crystal_out_pin_oe));
endmodule : clock_gen_assertions
bind mcu_clock_generation clock_gen_assertions clock_gen_assertions_inst (.*);
`default_nettype wire

//--- verif/tb.sv
// Purpose: Self-checking bench for the clock generator
// Assumes: Oscillators come from osc_sources; wake time shortened to 8
// Notes:   Gaps are measured between the 2nd and 3rd event to skip ratio changes
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, rc_clk, wdt_clk, xtal_clk;
  logic [2:0]  osc_config = 3'h3;
  logic [5:0]  factory_tune = 6'h00;
  logic [5:0]  rc_tune_value;
  logic        rtc_uses_crystal = 1'b0;
  logic        cpu_core_tick, machine_cycle_tick, periph_clock_tick;
  logic        low_power_clock_bit, crystal_out_pin_o, crystal_out_pin_oe;
  logic [31:0] seed = 32'hfbf1;
  int          fail_count = 0;
  int          n_tests = 0;
  int          g, t;
  int          dq[$] = '{0, 1, 2, 255};
  int          cfgs[6] = '{3, 4, 7, 2, 0, 5};
  int          pers[6] = '{8, 12, 10, 10, 10, 8};
  wire logic [2:0] ticks;
  // Tick outputs gathered for indexed gap measurement
  assign ticks = {periph_clock_tick, machine_cycle_tick, cpu_core_tick};
  always #4 core_clk = ~core_clk;
  osc_sources osc_sources_inst (.rc_clk(rc_clk), .wdt_clk(wdt_clk), .xtal_clk(xtal_clk));
  mcu_clock_generation #(.WAKE_TIME_CYCLES(8)) mcu_clock_generation_inst (
    .core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_rc_clock(rc_clk), .watchdog_osc_clock(wdt_clk),
    .crystal_in_pin(xtal_clk), .osc_config(osc_config), .factory_tune(factory_tune),
    .rtc_uses_crystal(rtc_uses_crystal), .cpu_core_tick(cpu_core_tick),
    .machine_cycle_tick(machine_cycle_tick), .periph_clock_tick(periph_clock_tick),
    .low_power_clock_bit(low_power_clock_bit), .rc_tune_value(rc_tune_value),
    .crystal_out_pin_o(crystal_out_pin_o), .crystal_out_pin_oe(crystal_out_pin_oe));
  // Xorshift source for random stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request is held until ready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rst(input logic p);
    @(posedge core_clk);
    rst_n <= 1'b0;
    por_n <= ~p;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask : rst
  // Cycles between two events: a tick pulse, or for s=3 a clock out toggle
  task gap(input int s, output int n);
    logic p;
    int k;
    k = 0;
    n = 0;
    while (k < 3 && n < 9000) begin
      p = crystal_out_pin_o;
      @(posedge core_clk);
      n++;
      if (s < 3 ? ticks[s] === 1'b1 : crystal_out_pin_o !== p) begin
        k++;
        if (k < 3) n = 0;
      end
    end
  endtask : gap
  task results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    #600000;
    fail_count++;
    results();
  end
  initial begin
    seed = rnd();
    factory_tune <= seed[5:0];
    rst(1'b1);
    apb(0, 12'h258, 0); chk(rd, {26'h0, factory_tune});
    apb(0, 12'h254, 0); chk(rd, 32'h0);
    apb(0, 12'h25c, 0); chk(rd, 32'h0);
    apb(1, 12'h264, 32'hff); chk({rd[30:0], er}, 32'h1);
    apb(0, 12'h264, 0); chk({rd[30:0], er}, 32'h1);
    seed = rnd();
    t = seed[5:0];
    apb(1, 12'h258, 32'h40 | t);
    apb(1, 12'h25c, 32'h80);
    apb(0, 12'h258, 0); chk(rd, 32'h40 | t);
    chk(low_power_clock_bit, 1); chk(rc_tune_value, t);
    rst(1'b0);
    apb(0, 12'h25c, 0); chk(rd, 32'h0); chk(low_power_clock_bit, 0);
    apb(0, 12'h258, 0); chk(rd, 32'h40 | t); chk(rc_tune_value, t);
    apb(1, 12'h258, 32'h40 | t);
    dq.push_back(1 + rnd() % 15);
    // Model ratio: 1 for zero, else twice the divide value, times the root period
    foreach (dq[i]) begin
      apb(1, 12'h254, dq[i]);
      for (int s = 0; s < 4; s++) begin
        if (s == 0 || dq[i] < 16) begin
          gap(s, g);
          chk(g, (dq[i] == 0 ? 1 : 2 * dq[i]) * 8 * (s == 1 || s == 2 ? 2 : 1));
        end
      end
    end
    // Each source is captured only at reset; the crystal waits out its wake-up
    for (int k = 0; k < 6; k++) begin
      osc_config <= 3'(cfgs[k]);
      rst(1'b0);
      t = 0;
      do begin
        apb(0, 12'h260, 0);
        t += 3;
      end while (rd[0] !== 1'b1 && t < 20000);
      if (cfgs[k] < 3) chk(t > 9900, 1);
      chk(rd, {26'h0, 3'(cfgs[k]), cfgs[k] < 3, cfgs[k] > 2, 1'b1});
      gap(0, g); chk(g, pers[k]);
      apb(1, 12'h258, 32'h40);
      repeat (3) @(posedge core_clk);
      chk(crystal_out_pin_oe, cfgs[k] > 2);
      rtc_uses_crystal <= 1'b1;
      // Two synchroniser stages plus the output flop
      repeat (4) @(posedge core_clk);
      chk(crystal_out_pin_oe, 0);
      rtc_uses_crystal <= 1'b0;
      apb(1, 12'h258, 32'h0);
      repeat (3) @(posedge core_clk);
      chk(crystal_out_pin_oe, 0);
    end
    results();
  end
endmodule : tb
`default_nettype wire
